// ---- rtl/temp_alarm.sv ----
// Temperature alarm, event output and conversion control
//
// Contract
// - Four hysteresis amounts apply to all limits
// - Hysteresis only on falling temperature
// - Hysteresis writes ignored while locked
// - Event pin driven only when enabled
// - Mode bit picks comparator or interrupt
// - Polarity bit picks active level
// - Above critical forces comparator style
// - Below critical minus hysteresis restores mode
// - Status bit shows event, zero in shutdown
// - Limit writes rejected while locked
// - Critical-only bit: critical comparator, mode ignored
// - Shutdown deasserts event until first conversion
// - Interrupt asserts on window limit crossings
// - Writing clear bit deasserts latched interrupt
// - Uncleared interrupt reasserts after first conversion
// - Critical interrupt holds until host clears
// - Interrupt to comparator switch deasserts event
// - Step register writable only in shutdown
// - Step selection readable in capability bits
// - Power-on step is quarter degree
// - Conversion period 30/65/130/260 ms per step
// - Step codes half, quarter, eighth, sixteenth
// - Shutdown bit halts sampling, clear resumes
`timescale 1ns/100ps
`default_nettype none

module temp_alarm #(
  parameter int CONV_CYC_HALF = temp_alarm_pkg::CONV_CYC_HALF,
  parameter int CONV_CYC_QUARTER = temp_alarm_pkg::CONV_CYC_QUARTER,
  parameter int CONV_CYC_EIGHTH = temp_alarm_pkg::CONV_CYC_EIGHTH,
  parameter int CONV_CYC_SIXTEENTH = temp_alarm_pkg::CONV_CYC_SIXTEENTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire temp_alarm_pkg::reg_req_t req_i,
  input wire logic [12:0] ambient_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic event_o,
  output logic event_oe_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (CONV_CYC_HALF < 1 || CONV_CYC_QUARTER < 1 || CONV_CYC_EIGHTH < 1 ||
      CONV_CYC_SIXTEENTH < 1 || CONV_CYC_SIXTEENTH > 8388607)
  begin : g_bad_period
    $error("conversion period out of range");
  end

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic signed [13:0] sx(input logic [12:0] v);
    sx = $signed({v[12], v});
  endfunction

  function automatic logic [22:0] period(input logic [1:0] step);
    unique case (step)
      2'h0: period = CONV_CYC_HALF[22:0];
      2'h1: period = CONV_CYC_QUARTER[22:0];
      2'h2: period = CONV_CYC_EIGHTH[22:0];
      2'h3: period = CONV_CYC_SIXTEENTH[22:0];
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [15:0] cfg_ff;
  logic [12:0] upper_ff, lower_ff, crit_ff, ambient_ff;
  logic [1:0] step_ff;
  temp_alarm_pkg::conv_state_t state_ff;
  logic [22:0] cnt_ff;
  logic valid_ff;
  logic upper_fl_ff, lower_fl_ff, crit_fl_ff;
  logic int_ff;
  logic active;
  logic conv_done;
  logic locked;
  logic shdn;
  logic wr_cfg;
  logic [13:0] hyst;
  logic signed [13:0] t_new;
  logic [12:0] sample;

  assign shdn = cfg_ff[temp_alarm_pkg::CFG_SHDN];
  assign locked = cfg_ff[temp_alarm_pkg::CFG_WIN_LOCK] |
                  cfg_ff[temp_alarm_pkg::CFG_CRIT_LOCK];
  assign wr_cfg = req_i.wr && req_i.addr == temp_alarm_pkg::ADDR_CONFIG;
  assign conv_done = state_ff == temp_alarm_pkg::CONV_RUN && cnt_ff == '0;

  always_comb
  begin
    unique case (cfg_ff[temp_alarm_pkg::CFG_HYST_LO +: 2])
      2'h0: hyst = temp_alarm_pkg::HYST_0;
      2'h1: hyst = temp_alarm_pkg::HYST_1;
      2'h2: hyst = temp_alarm_pkg::HYST_2;
      2'h3: hyst = temp_alarm_pkg::HYST_3;
    endcase
  end

  // Coarser steps drop the fraction bits the converter would not resolve
  always_comb
  begin
    unique case (step_ff)
      2'h0: sample = {ambient_i[12:3], 3'h0};
      2'h1: sample = {ambient_i[12:2], 2'h0};
      2'h2: sample = {ambient_i[12:1], 1'h0};
      2'h3: sample = ambient_i;
    endcase
  end
  assign t_new = sx(sample);

  // ----------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------
  // Lock bits stay set until reset, so a runaway write cannot unlock
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_ff <= temp_alarm_pkg::CONFIG_RST;
    else if (ce_i && wr_cfg)
    begin
      cfg_ff[3:0] <= req_i.wdata[3:0];
      cfg_ff[temp_alarm_pkg::CFG_WIN_LOCK] <= locked ? 1'b1 :
        req_i.wdata[temp_alarm_pkg::CFG_WIN_LOCK];
      cfg_ff[temp_alarm_pkg::CFG_CRIT_LOCK] <= locked ? 1'b1 :
        req_i.wdata[temp_alarm_pkg::CFG_CRIT_LOCK];
      if (!locked || !req_i.wdata[temp_alarm_pkg::CFG_SHDN])
        cfg_ff[temp_alarm_pkg::CFG_SHDN] <=
          req_i.wdata[temp_alarm_pkg::CFG_SHDN];
      if (!locked)
        cfg_ff[temp_alarm_pkg::CFG_HYST_LO +: 2] <=
          req_i.wdata[temp_alarm_pkg::CFG_HYST_LO +: 2];
    end
  end

  // ----------------------------------------------------------------------
  // Limit and step registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      upper_ff <= temp_alarm_pkg::LIMIT_RST;
      lower_ff <= temp_alarm_pkg::LIMIT_RST;
      crit_ff <= temp_alarm_pkg::LIMIT_RST;
    end
    else if (ce_i && req_i.wr && !locked)
    begin
      if (req_i.addr == temp_alarm_pkg::ADDR_UPPER)
        upper_ff <= req_i.wdata[12:0] & temp_alarm_pkg::LIMIT_MASK;
      if (req_i.addr == temp_alarm_pkg::ADDR_LOWER)
        lower_ff <= req_i.wdata[12:0] & temp_alarm_pkg::LIMIT_MASK;
      if (req_i.addr == temp_alarm_pkg::ADDR_CRIT)
        crit_ff <= req_i.wdata[12:0] & temp_alarm_pkg::LIMIT_MASK;
    end
  end

  // A finer step while running could stretch a conversion past its budget
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      step_ff <= temp_alarm_pkg::STEP_RST;
    else if (ce_i && req_i.wr && shdn &&
             req_i.addr == temp_alarm_pkg::ADDR_STEP)
      step_ff <= req_i.wdata[1:0];
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= temp_alarm_pkg::CONV_RUN;
      cnt_ff <= CONV_CYC_QUARTER[22:0] - 23'h000001;
      valid_ff <= 1'b0;
      ambient_ff <= temp_alarm_pkg::LIMIT_RST;
    end
    else if (ce_i)
    begin
      unique case (state_ff)
        temp_alarm_pkg::CONV_SHUT:
        begin
          if (!shdn)
          begin
            state_ff <= temp_alarm_pkg::CONV_RUN;
            cnt_ff <= period(step_ff) - 23'h000001;
          end
        end
        temp_alarm_pkg::CONV_RUN:
        begin
          if (shdn)
          begin
            state_ff <= temp_alarm_pkg::CONV_SHUT;
            valid_ff <= 1'b0;
          end
          else if (conv_done)
          begin
            cnt_ff <= period(step_ff) - 23'h000001;
            ambient_ff <= sample;
            valid_ff <= 1'b1;
          end
          else
            cnt_ff <= cnt_ff - 23'h000001;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Limit comparisons
  // ----------------------------------------------------------------------
  // Upper trips rising above and critical at the bare limit, both clear below limit - hyst; lower trips below limit - hyst, clears at limit;
  // inside the band the flag holds, so no fresh event is raised there
  logic nxt_upper_fl, nxt_lower_fl, nxt_crit_fl;
  assign nxt_upper_fl = (t_new > sx(upper_ff)) ||
    (upper_fl_ff && !(t_new < sx(upper_ff) - $signed(hyst)));
  assign nxt_lower_fl = (t_new < sx(lower_ff) - $signed(hyst)) ||
    (lower_fl_ff && !(t_new >= sx(lower_ff)));
  assign nxt_crit_fl = (t_new >= sx(crit_ff)) ||
    (crit_fl_ff && !(t_new < sx(crit_ff) - $signed(hyst)));
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      upper_fl_ff <= 1'b0;
      lower_fl_ff <= 1'b0;
      crit_fl_ff <= 1'b0;
    end
    else if (ce_i && conv_done && !shdn)
    begin
      upper_fl_ff <= nxt_upper_fl;
      lower_fl_ff <= nxt_lower_fl;
      crit_fl_ff <= nxt_crit_fl;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt latch
  // ----------------------------------------------------------------------
  logic win_change;
  logic crit_rise;
  assign win_change = nxt_upper_fl != upper_fl_ff ||
                      nxt_lower_fl != lower_fl_ff;
  assign crit_rise = nxt_crit_fl && !crit_fl_ff;

  // The latch survives shutdown so an unserviced event returns afterwards
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      int_ff <= 1'b0;
    else if (ce_i)
    begin
      if (conv_done && !shdn && (win_change || crit_rise))
        int_ff <= 1'b1;
      else if (wr_cfg && req_i.wdata[temp_alarm_pkg::CFG_INT_CLR])
        int_ff <= 1'b0;
      else if (wr_cfg && cfg_ff[temp_alarm_pkg::CFG_MODE] &&
               !req_i.wdata[temp_alarm_pkg::CFG_MODE])
        int_ff <= 1'b0;
    end
  end

  always_comb
  begin
    if (!valid_ff || shdn)
      active = 1'b0;
    else if (cfg_ff[temp_alarm_pkg::CFG_CRIT_ONLY])
      active = crit_fl_ff;
    else if (crit_fl_ff)
      active = 1'b1;
    else if (cfg_ff[temp_alarm_pkg::CFG_MODE])
      active = int_ff;
    else
      active = upper_fl_ff | lower_fl_ff;
  end

  // ----------------------------------------------------------------------
  // Event pin, open drain: released level relies on the pull-up
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      event_o <= 1'b0;
      event_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      event_o <= 1'b0;
      event_oe_o <= cfg_ff[temp_alarm_pkg::CFG_OUT_EN] &&
        (active == cfg_ff[temp_alarm_pkg::CFG_POL] ? 1'b0 : 1'b1);
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    unique case (req_i.addr)
      temp_alarm_pkg::ADDR_CAPABILITY:
      begin
        rd_mux = temp_alarm_pkg::CAP_FIXED;
        rd_mux[temp_alarm_pkg::CAP_STEP_LO +: 2] = step_ff;
      end
      temp_alarm_pkg::ADDR_CONFIG:
      begin
        rd_mux = cfg_ff;
        rd_mux[temp_alarm_pkg::CFG_STATUS] = active && !shdn;
        rd_mux[temp_alarm_pkg::CFG_INT_CLR] = 1'b0;
      end
      temp_alarm_pkg::ADDR_UPPER: rd_mux = {3'h0, upper_ff};
      temp_alarm_pkg::ADDR_LOWER: rd_mux = {3'h0, lower_ff};
      temp_alarm_pkg::ADDR_CRIT: rd_mux = {3'h0, crit_ff};
      temp_alarm_pkg::ADDR_AMBIENT:
        rd_mux = {crit_fl_ff, upper_fl_ff, lower_fl_ff, ambient_ff};
      temp_alarm_pkg::ADDR_STEP:
      begin
        rd_mux[1:0] = step_ff;
        rd_mux[temp_alarm_pkg::STEP_TOP_ONE] = 1'b1;
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      reg_rvalid_o <= req_i.rd;
      if (req_i.rd)
        reg_rdata_o <= rd_mux;
    end
  end

endmodule // temp_alarm

`default_nettype wire

// ---- rtl/temp_alarm_pkg.sv ----
// Package: register map, field layout, reset values and timing constants
package temp_alarm_pkg;

  // ----------------------------------------------------------------------
  // Register pointers
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CAPABILITY = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_UPPER = 4'h2;
  localparam logic [3:0] ADDR_LOWER = 4'h3;
  localparam logic [3:0] ADDR_CRIT = 4'h4;
  localparam logic [3:0] ADDR_AMBIENT = 4'h5;
  localparam logic [3:0] ADDR_STEP = 4'h9;

  // ----------------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------------
  localparam int CFG_MODE = 0;
  localparam int CFG_POL = 1;
  localparam int CFG_CRIT_ONLY = 2;
  localparam int CFG_OUT_EN = 3;
  localparam int CFG_STATUS = 4;
  localparam int CFG_INT_CLR = 5;
  localparam int CFG_WIN_LOCK = 6;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_SHDN = 8;
  localparam int CFG_HYST_LO = 9;
  localparam int CAP_STEP_LO = 3;
  localparam int STEP_TOP_ONE = 15;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [12:0] LIMIT_RST = 13'h0000;
  localparam logic [1:0] STEP_RST = 2'h1;
  localparam logic [15:0] CAP_FIXED = 16'h0001;
  localparam logic [12:0] LIMIT_MASK = 13'h1FFC;

  // Hysteresis in 1/16 degree units: 0, 1.5, 3, 6 degrees
  localparam logic [13:0] HYST_0 = 14'h0000;
  localparam logic [13:0] HYST_1 = 14'h0018;
  localparam logic [13:0] HYST_2 = 14'h0030;
  localparam logic [13:0] HYST_3 = 14'h0060;

  // ----------------------------------------------------------------------
  // Conversion periods
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ = 20000;
  localparam int CONV_MS_HALF = 30;
  localparam int CONV_MS_QUARTER = 65;
  localparam int CONV_MS_EIGHTH = 130;
  localparam int CONV_MS_SIXTEENTH = 260;
  localparam int CONV_CYC_HALF = CONV_MS_HALF * CLK_KHZ;
  localparam int CONV_CYC_QUARTER = CONV_MS_QUARTER * CLK_KHZ;
  localparam int CONV_CYC_EIGHTH = CONV_MS_EIGHTH * CLK_KHZ;
  localparam int CONV_CYC_SIXTEENTH = CONV_MS_SIXTEENTH * CLK_KHZ;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    CONV_SHUT = 2'b01,
    CONV_RUN = 2'b10
  } conv_state_t;

endpackage

// ---- test/host_irq_model.sv ----
// Host side: edge-triggered interrupt input on the event pin
`timescale 1ns/100ps
`default_nettype none
module host_irq_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic rise_sel_i,
  output logic [7:0] edge_cnt_o
);
  logic pin_ff;
  // Only the chosen transition counts, as a real edge input would
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      pin_ff <= 1'b1;
      edge_cnt_o <= 8'h00;
    end
    else
    begin
      pin_ff <= pin_i;
      if (pin_i != pin_ff && pin_i == rise_sel_i)
        edge_cnt_o <= edge_cnt_o + 8'h01;
    end
endmodule // host_irq_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Testbench for the temperature alarm block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  logic clk, rst, ce, rvalid, ev, oe, pin, sel;
  temp_alarm_pkg::reg_req_t req;
  logic [12:0] amb;
  logic [15:0] rdata;
  logic [7:0] ecnt, e0;
  int n_errors, total_checks, cyc;
  // Pull-up on the pin: high unless the device pulls it low
  assign pin = !oe;
  temp_alarm #(.CONV_CYC_HALF(20), .CONV_CYC_QUARTER(40),
    .CONV_CYC_EIGHTH(60), .CONV_CYC_SIXTEENTH(80)) dut (
    .ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .req_i(req),
    .ambient_i(amb), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .event_o(ev), .event_oe_o(oe));
  host_irq_model host (.ref_clk_i(clk), .rst_i(rst), .pin_i(pin),
    .rise_sel_i(sel), .edge_cnt_o(ecnt));
  task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m,
    input logic [15:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdata & m, e)
  endtask
  task automatic amb_to(input logic [12:0] v);
    @(posedge clk);
    amb <= v;
  endtask
  // Waits are bounded; a pin that never moves shows as a mismatch
  task automatic wait_pin(input logic e, input int n);
    for (int i = 0; i < n && pin !== e; i++)
      @(negedge clk);
    `CHK(pin, e)
  endtask
  task automatic hold_pin(input logic e, input int n);
    int bad;
    bad = 0;
    repeat (n)
    begin
      @(negedge clk);
      bad += (pin !== e);
    end
    `CHK(bad, 0)
  endtask
  task automatic t_reset;
    rd(4'h1, 16'hFFFF, 16'h0000);
    rd(4'h9, 16'hFFFF, 16'h8001);
    rd(4'h0, 16'h0019, 16'h0009);
    rd(4'hF, 16'hFFFF, 16'h0000);
    wr(4'h9, 16'h0003);
    rd(4'h9, 16'hFFFF, 16'h8001);
  endtask
  task automatic t_comp;
    wr(4'h2, 16'h0100);
    wr(4'h4, 16'h0400);
    wr(4'h1, 16'h020A);
    amb_to(13'h00FC);
    hold_pin(1'b0, 90);
    amb_to(13'h0104);
    wait_pin(1'b1, 50);
    rd(4'h1, 16'h0010, 16'h0010);
    amb_to(13'h00F0);
    hold_pin(1'b1, 90);
    amb_to(13'h00E0);
    wait_pin(1'b0, 50);
    wr(4'h1, 16'h0208);
    wait_pin(1'b1, 5);
    amb_to(13'h0104);
    wait_pin(1'b0, 50);
    wr(4'h1, 16'h0200);
    wait_pin(1'b1, 5);
    hold_pin(1'b1, 50);
  endtask
  task automatic t_int;
    // Drop any event latched while in comparator style
    wr(4'h1, 16'h022B);
    wait_pin(1'b0, 3);
    e0 = ecnt;
    amb_to(13'h0050);
    wait_pin(1'b1, 50);
    hold_pin(1'b1, 90);
    `CHK(ecnt, e0 + 8'h01)
    wr(4'h1, 16'h022B);
    wait_pin(1'b0, 3);
    hold_pin(1'b0, 90);
    amb_to(13'h0104);
    wait_pin(1'b1, 50);
    amb_to(13'h0050);
    hold_pin(1'b1, 50);
    wr(4'h1, 16'h020A);
    wait_pin(1'b0, 3);
  endtask
  task automatic critical_alarm_limit;
    wr(4'h1, 16'h020F);
    amb_to(13'h0104);
    hold_pin(1'b0, 90);
    amb_to(13'h0400);
    wait_pin(1'b1, 50);
    amb_to(13'h03F0);
    hold_pin(1'b1, 50);
    amb_to(13'h0050);
    wait_pin(1'b0, 50);
    wr(4'h1, 16'h022B);
    amb_to(13'h0400);
    wait_pin(1'b1, 50);
    amb_to(13'h0050);
    hold_pin(1'b1, 90);
    wr(4'h1, 16'h022B);
    wait_pin(1'b0, 3);
  endtask
  task automatic t_shdn;
    amb_to(13'h0104);
    wait_pin(1'b1, 50);
    wr(4'h1, 16'h030B);
    wait_pin(1'b0, 3);
    rd(4'h1, 16'h0110, 16'h0100);
    wr(4'h9, 16'h0003);
    rd(4'h9, 16'hFFFF, 16'h8003);
    rd(4'h0, 16'h0018, 16'h0018);
    hold_pin(1'b0, 100);
    wr(4'h1, 16'h020B);
    hold_pin(1'b0, 75);
    wait_pin(1'b1, 10);
  endtask
  task automatic t_lock;
    wr(4'h1, 16'h0280);
    wr(4'h2, 16'h0200);
    rd(4'h2, 16'hFFFF, 16'h0100);
    wr(4'h4, 16'h0000);
    rd(4'h4, 16'hFFFF, 16'h0400);
    wr(4'h1, 16'h0680);
    rd(4'h1, 16'h0680, 16'h0280);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run takes at most about 1400 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    {rst, ce, sel} = 3'b111;
    req = '0;
    amb = 13'h0050;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_comp();
    t_int();
    critical_alarm_limit();
    t_shdn();
    t_lock();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire

// ---- test/temp_alarm_asserts.sv ----
// Checker for the temperature alarm block
`timescale 1ns/100ps
`default_nettype none
module temp_alarm_asserts #(
  parameter int CONV_CYC_HALF = 20,
  parameter int CONV_CYC_QUARTER = 40,
  parameter int CONV_CYC_EIGHTH = 60,
  parameter int CONV_CYC_SIXTEENTH = 80
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire temp_alarm_pkg::reg_req_t req_i,
  input wire logic [12:0] ambient_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic event_o,
  input wire logic event_oe_o
);
  logic en_ff, pol_ff, lock_ff, shdn_ff;
  logic [1:0] step_ff, hy_ff;
  logic wr_cfg, rd_ok;
  assign wr_cfg = ce_i && req_i.wr && req_i.addr == 4'h1;
  assign rd_ok = ce_i && req_i.rd;
  // Shadow of config fields; locks are sticky until reset
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      {en_ff, pol_ff, lock_ff, shdn_ff, hy_ff} <= 6'h00;
      step_ff <= 2'h1;
    end
    else if (wr_cfg)
    begin
      en_ff <= req_i.wdata[3];
      pol_ff <= req_i.wdata[1];
      lock_ff <= lock_ff | req_i.wdata[6] | req_i.wdata[7];
      shdn_ff <= req_i.wdata[8] & (shdn_ff | ~lock_ff);
      hy_ff <= lock_ff ? hy_ff : req_i.wdata[10:9];
    end
    else if (ce_i && req_i.wr && req_i.addr == 4'h9 && shdn_ff)
      step_ff <= req_i.wdata[1:0];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_pin_data; !event_o; endproperty
  a_pin_data: assert property (p_pin_data)
    else $error("event data not low");
  property p_oe_off; !en_ff && !$past(en_ff) |-> !event_oe_o; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("pin driven while disabled");
  property p_clr_rd;
    rd_ok && req_i.addr == 4'h1 |=> reg_rvalid_o && !reg_rdata_o[5];
  endproperty
  a_clr_rd: assert property (p_clr_rd)
    else $error("clear bit reads back set");
  property p_hyst_rd;
    rd_ok && req_i.addr == 4'h1 |=> reg_rdata_o[10:9] == hy_ff;
  endproperty
  a_hyst_rd: assert property (p_hyst_rd)
    else $error("hysteresis field wrong");
  property p_step_rd;
    rd_ok && req_i.addr == 4'h9 |=> reg_rdata_o == {14'h2000, step_ff};
  endproperty
  a_step_rd: assert property (p_step_rd)
    else $error("step register wrong");
  property p_cap_rd;
    rd_ok && req_i.addr == 4'h0 |=> reg_rdata_o[4:3] == step_ff;
  endproperty
  a_cap_rd: assert property (p_cap_rd)
    else $error("capability step bits wrong");
  property p_shdn_st;
    shdn_ff && rd_ok && req_i.addr == 4'h1 |=> !reg_rdata_o[4];
  endproperty
  a_shdn_st: assert property (p_shdn_st)
    else $error("status set in shutdown");
  property p_shdn_pin;
    shdn_ff && $past(shdn_ff) && $stable(en_ff) && $stable(pol_ff)
      |-> event_oe_o == (en_ff && pol_ff);
  endproperty
  a_shdn_pin: assert property (p_shdn_pin)
    else $error("event asserted in shutdown");
  c_shdn: cover property (shdn_ff && wr_cfg);
  c_lock: cover property (lock_ff && wr_cfg);
  c_event: cover property ($rose(event_oe_o));
endmodule // temp_alarm_asserts

bind temp_alarm temp_alarm_asserts #(
  .CONV_CYC_HALF(CONV_CYC_HALF),
  .CONV_CYC_QUARTER(CONV_CYC_QUARTER),
  .CONV_CYC_EIGHTH(CONV_CYC_EIGHTH),
  .CONV_CYC_SIXTEENTH(CONV_CYC_SIXTEENTH)
) u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i),
  .ambient_i(ambient_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .event_o(event_o), .event_oe_o(event_oe_o)
);
`default_nettype wire
